/* File: eif_defs.vh */
// constants for the external interrupt edge filter, channels 3 and 4
`ifndef EIF_DEFS_VH
`define EIF_DEFS_VH
// ----------------------------------------
// register indices (printed offsets), byte address is four times the index
// ----------------------------------------
`define EIF_IDX_CH3_CONTROL 14'h0fda
`define EIF_IDX_CH4_CONTROL 14'h0fdb
`define EIF_ADDR_W 14
// ----------------------------------------
// control register fields
// ----------------------------------------
`define EIF_NC_LSB 0
`define EIF_NC_MSB 1
`define EIF_ES_LSB 2
`define EIF_ES_MSB 3
`define EIF_LVL_BIT 4
`define EIF_CTRL_RESET 3'h0
// ----------------------------------------
// edge select codes
// ----------------------------------------
`define EIF_ES_RISE 2'h0
`define EIF_ES_FALL 2'h1
`define EIF_ES_BOTH 2'h2
// ----------------------------------------
// sample interval codes and divider terminal counts
// ----------------------------------------
`define EIF_NC_DIV1 2'h0
`define EIF_NC_DIV4 2'h1
`define EIF_NC_DIV8 2'h2
`define EIF_NC_DIV16 2'h3
`define EIF_TC_DIV1 4'h0
`define EIF_TC_DIV4 4'h3
`define EIF_TC_DIV8 4'h7
`define EIF_TC_DIV16 4'hf
`define EIF_TC_SLOW 4'h3
// ----------------------------------------
// filter and bus constants
// ----------------------------------------
`define EIF_MATCH_NEEDED 2'h2
`define EIF_LAST_MATCH_FAST 2'h1
`define EIF_LAST_MATCH_SLOW 2'h0
`define EIF_ONE2 2'h1
`define EIF_ONE4 4'h1
`define EIF_HTRANS_NONSEQ_BIT 1
`define EIF_ZERO32 32'h0000_0000
`endif

/* File: eif_noise_filter.v */
// sampling noise canceller for one interrupt pin
`timescale 1ns/1ps
`default_nettype none
`include "eif_defs.vh"
module eif_noise_filter (
  input wire hclk,
  input wire hresetn,
  input wire pin_in,
  input wire slow_mode,
  input wire lf_tick,
  input wire [1:0] interval,
  output wire filtered
);
  reg [3:0] div_reg;
  reg [3:0] tc;
  reg [1:0] match_reg;
  reg cand_reg;
  reg filt_reg;
  wire sample;
  wire [1:0] last_match;
  // ----------------------------------------
  // sample strobe
  // ----------------------------------------
  always @* begin
    case (interval)
      `EIF_NC_DIV1: tc = `EIF_TC_DIV1;
      `EIF_NC_DIV4: tc = `EIF_TC_DIV4;
      `EIF_NC_DIV8: tc = `EIF_TC_DIV8;
      default: tc = `EIF_TC_DIV16;
    endcase
    if (slow_mode) begin
      tc = `EIF_TC_SLOW;
    end
  end
  // in slow mode the divider only advances on low-frequency ticks
  assign sample = (div_reg >= tc) && (!slow_mode || lf_tick);
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_reg <= `EIF_TC_DIV1;
    end else if (sample) begin
      div_reg <= `EIF_TC_DIV1;
    end else if (!slow_mode || lf_tick) begin
      div_reg <= div_reg + `EIF_ONE4;
    end
  end
  // ----------------------------------------
  // three equal samples accept a new level in fast modes, two in slow modes
  // ----------------------------------------
  // fast modes accept on the third equal sample, slow modes on the second:
  // slow samples sit 4/fs apart, so two of them split <4/fs noise from >=8/fs pulses
  assign last_match = slow_mode ? `EIF_LAST_MATCH_SLOW : `EIF_LAST_MATCH_FAST;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      match_reg <= 2'h0;
      cand_reg <= 1'b0;
      filt_reg <= 1'b0;
    end else if (sample) begin
      if (pin_in != cand_reg) begin
        cand_reg <= pin_in;
        match_reg <= 2'h0;
      end else begin
        if (match_reg < `EIF_MATCH_NEEDED) begin
          match_reg <= match_reg + `EIF_ONE2;
        end
        // >= so a mode switch in mid-count cannot strand the level
        if (match_reg >= last_match) begin
          filt_reg <= cand_reg;
        end
      end
    end
  end
  assign filtered = filt_reg;
endmodule // eif_noise_filter
`default_nettype wire

/* File: eif_edge_detect.v */
// edge select and level capture for one channel
`timescale 1ns/1ps
`default_nettype none
`include "eif_defs.vh"
module eif_edge_detect (
  input wire hclk,
  input wire hresetn,
  input wire filtered,
  input wire [1:0] edge_sel,
  output reg irq_pulse,
  output reg captured_level
);
  reg prev_reg;
  reg hit;
  wire rise;
  wire fall;
  assign rise = filtered & ~prev_reg;
  assign fall = ~filtered & prev_reg;
  always @* begin
    case (edge_sel)
      `EIF_ES_RISE: hit = rise;
      `EIF_ES_FALL: hit = fall;
      `EIF_ES_BOTH: hit = rise | fall;
      default: hit = 1'b0; // reserved code stays silent
    endcase
  end
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_reg <= 1'b0;
      irq_pulse <= 1'b0;
      captured_level <= 1'b0;
    end else begin
      prev_reg <= filtered;
      irq_pulse <= hit;
      if (hit) begin
        captured_level <= filtered; // held until next request
      end
    end
  end
endmodule // eif_edge_detect
`default_nettype wire

/* File: eif_ext_irq.v */
// external interrupt channels 3 and 4 with ahb-lite control registers
//
// Contract
// - edge code 00 rising, 01 falling, 10 both edges raise a request.
// - sample code picks gear clock /1,/4,/8,/16; slow modes always lf clock /4.
// - level bit reads filtered level at last request; 0 after reset.
// - level bit reloads on every request and holds until the next.
// - bits 7..5 of each control register read zero, writes ignored.
// - fast modes accept a level after three equal consecutive samples.
// - slow modes reject pulses under 4 lf periods, accept 8 or more.
`timescale 1ns/1ps
`default_nettype none
`include "eif_defs.vh"
module eif_ext_irq (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  input wire slow_mode,
  input wire lf_clock_tick,
  input wire ch3_pin,
  input wire ch4_pin,
  output wire ch3_irq,
  output wire ch4_irq
);
  // ----------------------------------------
  // control registers
  // ----------------------------------------
  reg [1:0] ch3_edge_select_reg;
  reg [1:0] ch3_sample_interval_reg;
  reg [1:0] ch4_edge_select_reg;
  reg [1:0] ch4_sample_interval_reg;
  reg wr_pend_reg;
  reg [`EIF_ADDR_W-1:0] wr_addr_reg;
  wire ch3_filtered;
  wire ch4_filtered;
  wire ch3_captured_level;
  wire ch4_captured_level;
  wire access;
  wire [`EIF_ADDR_W-1:0] word_addr;
  wire [7:0] ch3_rd;
  wire [7:0] ch4_rd;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign access = hsel && hready && htrans[`EIF_HTRANS_NONSEQ_BIT];
  assign word_addr = haddr[`EIF_ADDR_W+1:2];
  // ----------------------------------------
  // bus write: address captured, data applied in data phase
  // ----------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= {`EIF_ADDR_W{1'b0}};
    end else begin
      wr_pend_reg <= access && hwrite;
      if (access) begin
        wr_addr_reg <= word_addr;
      end
    end
  end
  // a write here can itself fire a request; software masks first
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ch3_edge_select_reg <= 2'h0;
      ch3_sample_interval_reg <= 2'h0;
      ch4_edge_select_reg <= 2'h0;
      ch4_sample_interval_reg <= 2'h0;
    end else if (wr_pend_reg) begin
      if (wr_addr_reg == `EIF_IDX_CH3_CONTROL) begin
        ch3_edge_select_reg <= hwdata[`EIF_ES_MSB:`EIF_ES_LSB];
        ch3_sample_interval_reg <= hwdata[`EIF_NC_MSB:`EIF_NC_LSB];
      end
      if (wr_addr_reg == `EIF_IDX_CH4_CONTROL) begin
        ch4_edge_select_reg <= hwdata[`EIF_ES_MSB:`EIF_ES_LSB];
        ch4_sample_interval_reg <= hwdata[`EIF_NC_MSB:`EIF_NC_LSB];
      end
    end
  end
  // ----------------------------------------
  // bus read: data registered from address phase
  // ----------------------------------------
  assign ch3_rd = {`EIF_CTRL_RESET, ch3_captured_level, ch3_edge_select_reg, ch3_sample_interval_reg};
  assign ch4_rd = {`EIF_CTRL_RESET, ch4_captured_level, ch4_edge_select_reg, ch4_sample_interval_reg};
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= `EIF_ZERO32;
    end else if (access && !hwrite) begin
      if (word_addr == `EIF_IDX_CH3_CONTROL) begin
        hrdata <= {24'h00_0000, ch3_rd};
      end else if (word_addr == `EIF_IDX_CH4_CONTROL) begin
        hrdata <= {24'h00_0000, ch4_rd};
      end else begin
        hrdata <= `EIF_ZERO32;
      end
    end
  end
  // ----------------------------------------
  // channels
  // ----------------------------------------
  // mode changes may glitch requests; masking is left to software
  eif_noise_filter u_ch3_filter (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_in(ch3_pin),
    .slow_mode(slow_mode),
    .lf_tick(lf_clock_tick),
    .interval(ch3_sample_interval_reg),
    .filtered(ch3_filtered)
  );
  eif_edge_detect u_ch3_edge (
    .hclk(hclk),
    .hresetn(hresetn),
    .filtered(ch3_filtered),
    .edge_sel(ch3_edge_select_reg),
    .irq_pulse(ch3_irq),
    .captured_level(ch3_captured_level)
  );
  eif_noise_filter u_ch4_filter (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_in(ch4_pin),
    .slow_mode(slow_mode),
    .lf_tick(lf_clock_tick),
    .interval(ch4_sample_interval_reg),
    .filtered(ch4_filtered)
  );
  eif_edge_detect u_ch4_edge (
    .hclk(hclk),
    .hresetn(hresetn),
    .filtered(ch4_filtered),
    .edge_sel(ch4_edge_select_reg),
    .irq_pulse(ch4_irq),
    .captured_level(ch4_captured_level)
  );
endmodule // eif_ext_irq
`default_nettype wire

/* File: eif_ext_irq_checker.sv */
// port assertions for eif_ext_irq
`timescale 1ns/1ps
`default_nettype none
module eif_ext_irq_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic slow_mode,
  input wire logic ch3_pin,
  input wire logic ch4_pin,
  input wire logic ch3_irq,
  input wire logic ch4_irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire logic rd = hsel && htrans[1] && !hwrite;
  wire logic rd3 = rd && haddr == 32'h0000_3f68;
  logic seen3_reg;
  logic [7:0] quiet_reg;
  // slowest filter setting (/16) needs ~50 cycles, so 255 quiet cycles is a safe bound
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seen3_reg <= 1'b0;
      quiet_reg <= 8'h00;
    end else begin
      seen3_reg <= seen3_reg | ch3_irq;
      if ($changed({ch3_pin, ch4_pin, slow_mode}) || (hsel && htrans[1] && hwrite))
        quiet_reg <= 8'h00;
      else if (quiet_reg != 8'hff)
        quiet_reg <= quiet_reg + 8'h01;
    end
  end
  // ----
  // assertions
  // ----
  chk_okay_resp: assert property (!hresp) else $error("bad resp");
  chk_zero_wait: assert property (hreadyout) else $error("wait state");
  chk_upper_zero: assert property (~|hrdata[31:5]) else $error("upper bits");
  chk_irq3_pulse: assert property (ch3_irq |=> !ch3_irq) else $error("ch3 long");
  chk_irq4_pulse: assert property (ch4_irq |=> !ch4_irq) else $error("ch4 long");
  chk_no_cause: assert property (quiet_reg == 8'hff |-> !ch3_irq && !ch4_irq)
    else $error("idle request");
  chk_level_init: assert property (rd3 && !seen3_reg && !ch3_irq |=> !hrdata[4])
    else $error("early level");
  chk_read_hold: assert property (!rd |=> $stable(hrdata)) else $error("data moved");
  cov_ch3: cover property (ch3_irq);
  cov_ch4: cover property (ch4_irq);
  cov_slow: cover property (slow_mode && ch3_irq);
endmodule // eif_ext_irq_checker
bind eif_ext_irq eif_ext_irq_checker u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .slow_mode(slow_mode), .ch3_pin(ch3_pin), .ch4_pin(ch4_pin), .ch3_irq(ch3_irq), .ch4_irq(ch4_irq));
`default_nettype wire

/* File: eif_pin_src.sv */
// board pin sources and lf clock
`timescale 1ns/1ps
`default_nettype none
module eif_pin_src (
  input wire logic hclk,
  output var logic [1:0] pins,
  output var logic lf_tick
);
  logic [1:0] div_reg = 2'h0;
  initial pins = 2'h0;
  initial lf_tick = 1'b0;
  // lf clock at a quarter of hclk, far too fast for silicon but keeps runs short
  always @(posedge hclk) begin
    div_reg <= div_reg + 2'h1;
    lf_tick <= div_reg == 2'h3;
  end
  task automatic drive(input int ch, input logic lvl, input int n);
    pins[ch] <= lvl;
    repeat (n) @(posedge hclk);
  endtask
endmodule // eif_pin_src
`default_nettype wire

/* File: eif_ext_irq_tb_top.sv */
// bench for external interrupt channels 3 and 4
`timescale 1ns/1ps
`default_nettype none
module eif_ext_irq_tb_top;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, slow_mode = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rv;
  logic [1:0] pins, irq;
  logic hreadyout, hresp, lf_tick;
  int bad_count = 0, n_checks = 0;
  int cnt[2] = '{0, 0};
  always #25 hclk = ~hclk;
  always @(posedge hclk) begin
    cnt[0] <= cnt[0] + int'(irq[0] === 1'b1);
    cnt[1] <= cnt[1] + int'(irq[1] === 1'b1);
  end
  eif_pin_src src (.hclk(hclk), .pins(pins), .lf_tick(lf_tick));
  eif_ext_irq dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .slow_mode(slow_mode), .lf_clock_tick(lf_tick), .ch3_pin(pins[0]), .ch4_pin(pins[1]), .ch3_irq(irq[0]),
    .ch4_irq(irq[1]));
  // ----
  // shared tasks
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // ch 2 lands on an unmapped word
  task automatic xfer(input logic wr, input int ch, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= 32'h0000_3f68 + 32'(4 * ch);
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rv = hrdata;
  endtask
  task automatic t_regs;
    for (int ch = 0; ch < 3; ch++) begin
      xfer(1'b0, ch, 32'h0000_0000);
      chk(rv, 32'h0000_0000);
      xfer(1'b1, ch, 32'hffff_ffff);
      xfer(1'b0, ch, 32'h0000_0000);
      chk(rv, ch == 2 ? 32'h0000_0000 : 32'h0000_000f);
    end
  endtask
  task automatic t_edges;
    int b;
    logic lvl;
    for (int ch = 0; ch < 2; ch++) begin
      lvl = 1'b0;
      for (int es = 0; es < 4; es++) begin
        xfer(1'b1, ch, 32'(es << 2));
        for (int k = 1; k >= 0; k--) begin
          b = cnt[ch];
          src.drive(ch, k[0], 12);
          chk(cnt[ch] - b, 32'(es == 2 || es == 1 - k));
          if (es == 2 || es == 1 - k)
            lvl = k[0];
          xfer(1'b0, ch, 32'h0000_0000);
          chk(rv, 32'({lvl, 4'(es << 2)}));
        end
      end
    end
  endtask
  // 2d wide pulse meets two samples only, 3d wide meets three
  task automatic t_interval;
    int b, d;
    for (int nc = 0; nc < 4; nc++) begin
      d = nc == 0 ? 1 : 2 << nc;
      xfer(1'b1, 0, 32'(nc));
      b = cnt[0];
      src.drive(0, 1'b1, 2 * d);
      src.drive(0, 1'b0, 8 * d + 8);
      src.drive(0, 1'b1, 3 * d);
      src.drive(0, 1'b0, 8 * d + 8);
      chk(cnt[0] - b, 32'h0000_0001);
    end
  endtask
  // one lf period is four hclk cycles
  task automatic t_slow;
    int b;
    slow_mode <= 1'b1;
    repeat (48) @(posedge hclk);
    b = cnt[0];
    src.drive(0, 1'b1, 12);
    src.drive(0, 1'b0, 100);
    src.drive(0, 1'b1, 32);
    src.drive(0, 1'b0, 100);
    chk(cnt[0] - b, 32'h0000_0001);
    slow_mode <= 1'b0;
    // needs 2 + 3 * 16 cycles at the slowest interval; the long idle also arms the quiet check
    repeat (300) @(posedge hclk);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    #1_000_000;
    bad_count++;
    end_sim;
  end
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs;
    t_edges;
    t_interval;
    t_slow;
    end_sim;
  end
endmodule // eif_ext_irq_tb_top
`default_nettype wire
